// >>> common/tcwq_pkg.sv
// constants, register map and carrier types of the waveform timer channel
package tcwq_pkg;
  localparam int CNT_W = 32;
  localparam int DIV_DEFAULT = 8;

  typedef logic [7:0] tcwq_addr_t;
  typedef logic [CNT_W-1:0] tcwq_word_t;

  localparam tcwq_addr_t OFS_MODE = 8'h00;
  localparam tcwq_addr_t OFS_EXT = 8'h04;
  localparam tcwq_addr_t OFS_CTRL = 8'h08;
  localparam tcwq_addr_t OFS_CMP_A = 8'h0c;
  localparam tcwq_addr_t OFS_CMP_B = 8'h10;
  localparam tcwq_addr_t OFS_CMP_C = 8'h14;
  localparam tcwq_addr_t OFS_CV = 8'h18;
  localparam tcwq_addr_t OFS_STATUS = 8'h1c;
  localparam tcwq_addr_t OFS_CAPTURE = 8'h20;

  localparam int CTRL_CLKEN_BIT = 0;
  localparam int CTRL_CLKDIS_BIT = 1;
  localparam int CTRL_SWTRG_BIT = 2;
  localparam int ST_OVF_BIT = 0;
  localparam int ST_MC_BIT = 1;
  localparam int ST_CLKSTA_BIT = 2;
  localparam int ST_CLKRUN_BIT = 3;

  localparam logic [1:0] SHAPE_UP_FULL = 2'h0;
  localparam logic [1:0] SHAPE_UPDN_FULL = 2'h1;
  localparam logic [1:0] SHAPE_UP_C = 2'h2;
  localparam logic [1:0] SHAPE_UPDN_C = 2'h3;

  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_SET = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  localparam logic [2:0] CLK_MCLK = 3'h0;
  localparam logic [2:0] CLK_DIV = 3'h1;
  localparam logic [2:0] CLK_X0 = 3'h5;
  localparam logic [2:0] CLK_X1 = 3'h6;
  localparam logic [2:0] CLK_X2 = 3'h7;

  localparam logic [1:0] EVT_LINE_B = 2'h0;
  localparam logic [1:0] EVT_X0 = 2'h1;
  localparam logic [1:0] EVT_X1 = 2'h2;
  localparam logic [1:0] EVT_X2 = 2'h3;

  localparam logic [1:0] ETRG_LINE_A = 2'h0;
  localparam logic [1:0] ETRG_LINE_B = 2'h1;
  localparam logic [1:0] ETRG_PWM = 2'h2;

  typedef struct packed {
    logic pad;
    logic [1:0] act_s_b;
    logic [1:0] act_e_b;
    logic [1:0] act_c_b;
    logic [1:0] act_b_b;
    logic [1:0] act_s_a;
    logic [1:0] act_e_a;
    logic [1:0] act_c_a;
    logic [1:0] act_a_a;
    logic [1:0] etrg_edge;
    logic [1:0] etrg_src;
    logic evt_trig_en;
    logic [1:0] evt_edge;
    logic [1:0] evt_src;
    logic c_trig;
    logic c_dis;
    logic c_stop;
    logic [1:0] shape;
    logic wave;
  } tcwq_mode_t;

  typedef struct packed {
    logic [25:0] pad;
    logic [2:0] clk_sel;
    logic qd_en;
    logic trig_b;
    logic trig_a;
  } tcwq_ext_t;

  typedef struct packed {
    tcwq_mode_t mode;
    tcwq_ext_t ext;
    tcwq_word_t cmp_a;
    tcwq_word_t cmp_b;
    tcwq_word_t cmp_c;
    tcwq_word_t cv;
    tcwq_word_t cap;
    tcwq_word_t rdata;
    logic [7:0] pre_cnt;
    logic dir_down;
    logic clk_en;
    logic clk_run;
    logic trig_pend;
    logic ovf;
    logic mc;
    logic dma;
    logic line_a;
    logic line_b;
    logic ch1;
    logic pa;
    logic pb;
    logic qa;
    logic qb;
    logic px0;
    logic px1;
    logic px2;
    logic ppwm;
    logic pb1;
  } tcwq_state_t;

  localparam tcwq_state_t STATE_RST = '0;
endpackage

// >>> rtl/tcwq_channel.sv
// waveform timer channel with trigger logic and decoder front end
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/10ps
// Function
// - capture values raise a transfer request only in capture mode
// - capture mode trigger comes from line A, line B or pwm trigger
// - trigger edge is rising, falling or both; zero disables it
// - waveform bit selects waveform generation mode
// - line A always drives in waveform mode, line B unless event
// - compares A, B, C act on lines A, B and either line
// - shape 00 counts up to full range, wraps to zero, repeats
// - in shapes 00 and 10 a trigger clears the counter
// - in shapes 00 and 01 a compare C match never triggers
// - compare C match stops or disables the counter clock
// - shape 10 counts up to compare C then restarts at zero
// - shape 01 counts up to full range then down to zero
// - shape 11 counts up to compare C then down to zero
// - in up/down shapes a trigger reverses counting direction
// - event source is ext clock 0..2 or line B, with edge select
// - line B as event source stops line B output and compare B
// - events trigger only when enabled; sync and software always
// - line trigger sources may be replaced by pwm comparator outputs
// - software trigger, event and compare C set, clear or toggle the lines
// - decoder disabled routes the index line straight to the channel 1 clock
// - counting up passes full range to zero setting overflow flag
// - a trigger takes effect at the next counter clock edge
module tcwq_channel
#(
  parameter int CLK_DIVIDE = tcwq_pkg::DIV_DEFAULT
)
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic CE,
  input wire tcwq_pkg::tcwq_addr_t ADDR,
  input wire tcwq_pkg::tcwq_word_t WDATA,
  input wire logic WR,
  input wire logic RD,
  output tcwq_pkg::tcwq_word_t RDATA,
  input wire logic SYNC,
  input wire logic EXT_CLK0_I,
  input wire logic EXT_CLK1_I,
  input wire logic EXT_CLK2_I,
  input wire logic LINE_A_I,
  output logic LINE_A_O,
  output logic LINE_A_OE_N,
  input wire logic LINE_B_I,
  output logic LINE_B_O,
  output logic LINE_B_OE_N,
  input wire logic LINE_B1_I,
  input wire logic PWM_CMP_A,
  input wire logic PWM_CMP_B,
  input wire logic PWM_TRIG,
  output logic DMA_REQ,
  output logic CH1_CLK_O
);
  import tcwq_pkg::*;

  if (CLK_DIVIDE < 2 || CLK_DIVIDE > 256)
  begin : div_check
    $error("clock divide must be 2 to 256");
  end

  localparam logic [7:0] DIV_M1 = 8'(CLK_DIVIDE - 1);

  tcwq_state_t s_reg;
  tcwq_state_t s_next;
  logic wr_ctrl;
  logic sw_trg;
  logic st_rd;
  logic a_eff;
  logic b_eff;
  logic qd_edge;
  logic x0_hit;
  logic etrg_hit;
  logic evt_hit;
  logic ext_trg;
  logic ctrig;
  logic trig_any;
  logic tick;
  logic cnt_go;
  logic updown;
  logic b_out_en;
  tcwq_word_t top;
  tcwq_word_t cv_new;
  logic d;
  logic ovf_set;
  logic hit_a;
  logic hit_b;
  logic mc_hit;
  logic la;
  logic lb;

  function automatic logic edge_hit(input logic prev, input logic cur,
                                    input logic [1:0] sel);
    logic r;
    r = 1'b0;
    unique case (sel)
      EDGE_NONE: r = 1'b0;
      EDGE_RISE: r = cur && !prev;
      EDGE_FALL: r = !cur && prev;
      EDGE_BOTH: r = cur ^ prev;
    endcase
    return r;
  endfunction

  function automatic logic out_act(input logic v, input logic [1:0] act);
    logic r;
    r = v;
    unique case (act)
      ACT_NONE: r = v;
      ACT_SET: r = 1'b1;
      ACT_CLEAR: r = 1'b0;
      ACT_TOGGLE: r = !v;
    endcase
    return r;
  endfunction

  assign wr_ctrl = WR && (ADDR == OFS_CTRL);
  assign sw_trg = wr_ctrl && WDATA[CTRL_SWTRG_BIT];
  assign st_rd = RD && (ADDR == OFS_STATUS);
  assign a_eff = s_reg.ext.trig_a ? PWM_CMP_A : LINE_A_I;
  assign b_eff = s_reg.ext.trig_b ? PWM_CMP_B : LINE_B_I;
  // decoder counts every phase edge; bypassed it is the rising edge of ext clock 0
  assign qd_edge = (LINE_A_I ^ s_reg.qa) || (LINE_B_I ^ s_reg.qb);
  assign x0_hit = s_reg.ext.qd_en ? qd_edge
                : (EXT_CLK0_I && !s_reg.px0);
  assign updown = s_reg.mode.wave && s_reg.mode.shape[0];
  assign top = s_reg.mode.shape[1] ? s_reg.cmp_c : '1;
  assign b_out_en = s_reg.mode.wave && (s_reg.mode.evt_src != EVT_LINE_B);

  always_comb
  begin
    etrg_hit = 1'b0;
    unique case (s_reg.mode.etrg_src)
      ETRG_LINE_A: etrg_hit = edge_hit(s_reg.pa, a_eff,
                                       s_reg.mode.etrg_edge);
      ETRG_LINE_B: etrg_hit = edge_hit(s_reg.pb, b_eff,
                                       s_reg.mode.etrg_edge);
      ETRG_PWM: etrg_hit = edge_hit(s_reg.ppwm, PWM_TRIG,
                                    s_reg.mode.etrg_edge);
      default: etrg_hit = 1'b0;
    endcase
    evt_hit = 1'b0;
    unique case (s_reg.mode.evt_src)
      EVT_LINE_B: evt_hit = edge_hit(s_reg.pb, b_eff, s_reg.mode.evt_edge);
      EVT_X0: evt_hit = s_reg.ext.qd_en
                        ? (qd_edge && s_reg.mode.evt_edge != EDGE_NONE)
                        : edge_hit(s_reg.px0, EXT_CLK0_I,
                                   s_reg.mode.evt_edge);
      EVT_X1: evt_hit = edge_hit(s_reg.px1, EXT_CLK1_I, s_reg.mode.evt_edge);
      EVT_X2: evt_hit = edge_hit(s_reg.px2, EXT_CLK2_I, s_reg.mode.evt_edge);
    endcase
    tick = 1'b0;
    unique case (s_reg.ext.clk_sel)
      CLK_MCLK: tick = 1'b1;
      CLK_DIV: tick = (s_reg.pre_cnt == DIV_M1);
      CLK_X0: tick = x0_hit;
      CLK_X1: tick = EXT_CLK1_I && !s_reg.px1;
      CLK_X2: tick = EXT_CLK2_I && !s_reg.px2;
      default: tick = 1'b0;
    endcase
  end

  // event triggers only when enabled; capture uses its own trigger
  assign ext_trg = s_reg.mode.wave ? (evt_hit && s_reg.mode.evt_trig_en)
                 : etrg_hit;
  assign cnt_go = tick && s_reg.clk_en && s_reg.clk_run;

  always_comb
  begin
    s_next = s_reg;
    d = s_reg.dir_down;
    cv_new = s_reg.cv;
    ovf_set = 1'b0;
    hit_a = 1'b0;
    hit_b = 1'b0;
    mc_hit = 1'b0;
    ctrig = 1'b0;
    trig_any = 1'b0;
    la = s_reg.line_a;
    lb = s_reg.line_b;
    if (CE)
    begin
      s_next.pa = a_eff;
      s_next.pb = b_eff;
      s_next.qa = LINE_A_I;
      s_next.qb = LINE_B_I;
      s_next.px0 = EXT_CLK0_I;
      s_next.px1 = EXT_CLK1_I;
      s_next.px2 = EXT_CLK2_I;
      s_next.ppwm = PWM_TRIG;
      s_next.pb1 = LINE_B1_I;
      s_next.pre_cnt = (s_reg.pre_cnt == DIV_M1) ? 8'h00
                     : s_reg.pre_cnt + 8'h01;
      // counter advances only on a counter clock edge
      if (cnt_go)
      begin
        if (s_reg.trig_pend && updown)
        begin
          d = !d;
        end
        if (s_reg.trig_pend && !updown)
        begin
          cv_new = '0;
        end
        else if (updown)
        begin
          if (!d)
          begin
            if (s_reg.cv == top)
            begin
              d = 1'b1;
              cv_new = s_reg.cv - 32'h1;
            end
            else
            begin
              cv_new = s_reg.cv + 32'h1;
            end
          end
          else if (s_reg.cv == '0)
          begin
            d = 1'b0;
            cv_new = s_reg.cv + 32'h1;
          end
          else
          begin
            cv_new = s_reg.cv - 32'h1;
          end
        end
        else if (s_reg.mode.wave && s_reg.mode.shape == SHAPE_UP_C
                 && s_reg.cv == s_reg.cmp_c)
        begin
          cv_new = '0;
        end
        else
        begin
          cv_new = s_reg.cv + 32'h1;
          ovf_set = (s_reg.cv == '1);
        end
        s_next.cv = cv_new;
        s_next.dir_down = d;
        s_next.trig_pend = 1'b0;
        hit_a = (cv_new == s_reg.cmp_a);
        hit_b = (cv_new == s_reg.cmp_b) && b_out_en;
        mc_hit = (cv_new == s_reg.cmp_c);
      end
      if (mc_hit && s_reg.mode.c_stop)
      begin
        s_next.clk_run = 1'b0;
      end
      if (mc_hit && s_reg.mode.c_dis)
      begin
        s_next.clk_en = 1'b0;
      end
      // waveform shapes handle compare C themselves, never as a trigger
      ctrig = mc_hit && s_reg.mode.c_trig && !s_reg.mode.wave;
      trig_any = sw_trg || SYNC || ext_trg || ctrig;
      if (trig_any)
      begin
        s_next.trig_pend = 1'b1;
        if (s_next.clk_en)
        begin
          s_next.clk_run = 1'b1;
        end
      end
      if (wr_ctrl && WDATA[CTRL_CLKEN_BIT])
      begin
        s_next.clk_en = 1'b1;
      end
      if (wr_ctrl && WDATA[CTRL_CLKDIS_BIT])
      begin
        s_next.clk_en = 1'b0;
        s_next.clk_run = 1'b0;
      end
      // later events win: compare, then C, event, software trigger
      if (s_reg.mode.wave)
      begin
        if (hit_a)
        begin
          la = out_act(la, s_reg.mode.act_a_a);
        end
        if (mc_hit)
        begin
          la = out_act(la, s_reg.mode.act_c_a);
        end
        if (evt_hit)
        begin
          la = out_act(la, s_reg.mode.act_e_a);
        end
        if (sw_trg)
        begin
          la = out_act(la, s_reg.mode.act_s_a);
        end
        if (b_out_en)
        begin
          if (hit_b)
          begin
            lb = out_act(lb, s_reg.mode.act_b_b);
          end
          if (mc_hit)
          begin
            lb = out_act(lb, s_reg.mode.act_c_b);
          end
          if (evt_hit)
          begin
            lb = out_act(lb, s_reg.mode.act_e_b);
          end
          if (sw_trg)
          begin
            lb = out_act(lb, s_reg.mode.act_s_b);
          end
        end
      end
      s_next.line_a = la;
      s_next.line_b = lb;
      s_next.dma = !s_reg.mode.wave && etrg_hit;
      if (!s_reg.mode.wave && etrg_hit)
      begin
        s_next.cap = s_reg.cv;
      end
      // a flag set in the cycle of its clearing read stays set
      s_next.ovf = ovf_set || (s_reg.ovf && !st_rd);
      s_next.mc = mc_hit || (s_reg.mc && !st_rd);
      s_next.ch1 = s_reg.ext.qd_en ? (LINE_B1_I && !s_reg.pb1)
                 : LINE_B1_I;
      if (WR)
      begin
        unique case (ADDR)
          OFS_MODE: s_next.mode = tcwq_mode_t'(WDATA);
          OFS_EXT: s_next.ext = tcwq_ext_t'(WDATA);
          OFS_CMP_A: s_next.cmp_a = WDATA;
          OFS_CMP_B: s_next.cmp_b = WDATA;
          OFS_CMP_C: s_next.cmp_c = WDATA;
          default: s_next.cmp_a = s_next.cmp_a;
        endcase
      end
      s_next.rdata = '0;
      if (RD)
      begin
        unique case (ADDR)
          OFS_MODE: s_next.rdata = s_reg.mode;
          OFS_EXT: s_next.rdata = s_reg.ext;
          OFS_CMP_A: s_next.rdata = s_reg.cmp_a;
          OFS_CMP_B: s_next.rdata = s_reg.cmp_b;
          OFS_CMP_C: s_next.rdata = s_reg.cmp_c;
          OFS_CV: s_next.rdata = s_reg.cv;
          OFS_CAPTURE: s_next.rdata = s_reg.cap;
          OFS_STATUS: s_next.rdata = {28'h0000000, s_reg.clk_run,
                                      s_reg.clk_en, s_reg.mc, s_reg.ovf};
          default: s_next.rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      s_reg <= STATE_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign RDATA = s_reg.rdata;
  assign LINE_A_O = s_reg.line_a;
  assign LINE_A_OE_N = !s_reg.mode.wave;
  assign LINE_B_O = s_reg.line_b;
  assign LINE_B_OE_N = !b_out_en;
  assign DMA_REQ = s_reg.dma;
  assign CH1_CLK_O = s_reg.ch1;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);

  AST_DMA_CAPTURE_ONLY: assert property (
    s_reg.dma |-> !$past(s_reg.mode.wave))
    else $error("transfer request raised in waveform mode");

  AST_ETRG_NONE: assert property (
    CE && !s_reg.mode.wave && s_reg.mode.etrg_edge == EDGE_NONE
    |=> !s_reg.dma)
    else $error("disabled external trigger raised a request");

  // pin is an input then, so the held level must not move
  AST_LINE_B_INPUT: assert property (
    CE && s_reg.mode.evt_src == EVT_LINE_B
    |=> $stable(s_reg.line_b))
    else $error("line B changed while used as event");

  AST_WRAP_FULL: assert property (
    CE && cnt_go && !s_reg.trig_pend && s_reg.mode.wave
    && s_reg.mode.shape == SHAPE_UP_FULL && s_reg.cv == '1
    |=> s_reg.cv == '0 && s_reg.ovf)
    else $error("full range wrap or overflow flag wrong");

  AST_WRAP_C: assert property (
    CE && cnt_go && !s_reg.trig_pend && s_reg.mode.wave
    && s_reg.mode.shape == SHAPE_UP_C && s_reg.cv == s_reg.cmp_c
    |=> s_reg.cv == '0)
    else $error("counter did not restart at compare C");

  AST_TURN_C: assert property (
    CE && cnt_go && !s_reg.trig_pend && s_reg.mode.wave
    && s_reg.mode.shape == SHAPE_UPDN_C && !s_reg.dir_down
    && s_reg.cv == s_reg.cmp_c && s_reg.cv != '0
    |=> s_reg.dir_down && s_reg.cv == $past(s_reg.cv) - 32'h1)
    else $error("counter did not turn down at compare C");

  AST_MATCH_DISABLE: assert property (
    CE && mc_hit && s_reg.mode.c_dis && !wr_ctrl |=> !s_reg.clk_en)
    else $error("compare C match failed to disable clock");

  AST_TRIG_PENDS: assert property (
    CE && sw_trg
    |=> s_reg.trig_pend && (s_reg.cv == $past(s_reg.cv) || $past(cnt_go)))
    else $error("software trigger not held for next counter edge");

  AST_TRIG_REVERSE: assert property (
    CE && cnt_go && s_reg.trig_pend && updown && s_reg.cv != '0
    && s_reg.cv != top |=> s_reg.dir_down != $past(s_reg.dir_down))
    else $error("trigger did not reverse direction");

  AST_MATCH_FLAG: assert property (
    CE && mc_hit |=> s_reg.mc [*2] or (s_reg.mc ##1 1'b1))
    else $error("compare C match flag not set");
endmodule

// >>> verification/tcwq_encoder_model.sv
// rotary encoder model driving the two phase lines and the index line
`timescale 1ns/10ps
module tcwq_encoder_model
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic step,
  input wire logic dir_down,
  output logic phase_a,
  output logic phase_b,
  output logic index
);
  logic [1:0] pos_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pos_reg <= 2'h0;
    else if (step)
      pos_reg <= dir_down ? pos_reg - 2'h1 : pos_reg + 2'h1;
  end

  // gray code: one phase moves per step, so every step is one edge
  assign phase_a = pos_reg[1];
  assign phase_b = pos_reg[1] ^ pos_reg[0];
  // index high at one position only, one rise per turn
  assign index = (pos_reg == 2'h0);
endmodule

// >>> verification/timer_waveform_trigger_quad_decoder_test.sv
// self-checking bench of the waveform timer channel
`timescale 1ns/10ps
module timer_waveform_trigger_quad_decoder_test;
  import tcwq_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic sync_s = 1'b0;
  logic pwm_a = 1'b0;
  logic pwm_t = 1'b0;
  logic step = 1'b0;
  logic dir_dn = 1'b0;
  tcwq_addr_t addr = '0;
  tcwq_word_t wdata = '0;
  tcwq_word_t rdata, v0, v1, v2, c, mx;
  tcwq_mode_t m;
  tcwq_ext_t e;
  logic lao, laoe_n, lbo, lboe_n, dma, ch1, ph_a, ph_b, idx, down, ea;
  int num_errors = 0;
  int comparisons = 0;
  int dma_cnt = 0;
  int seed = 20;
  int n;

  always #12.5 mclk = ~mclk;

  always @(posedge mclk)
    if (dma === 1'b1)
      dma_cnt++;

  tcwq_channel tcwq_channel_inst (.MCLK(mclk), .RESET_N(reset_n), .CE(1'b1),
    .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
    .SYNC(sync_s), .EXT_CLK0_I(1'b0), .EXT_CLK1_I(1'b0), .EXT_CLK2_I(1'b0),
    .LINE_A_I(ph_a), .LINE_A_O(lao), .LINE_A_OE_N(laoe_n), .LINE_B_I(ph_b),
    .LINE_B_O(lbo), .LINE_B_OE_N(lboe_n), .LINE_B1_I(idx),
    .PWM_CMP_A(pwm_a), .PWM_CMP_B(1'b0), .PWM_TRIG(pwm_t), .DMA_REQ(dma),
    .CH1_CLK_O(ch1));

  tcwq_encoder_model tcwq_encoder_model_inst (.clk(mclk), .rst_n(reset_n),
    .step(step), .dir_down(dir_dn), .phase_a(ph_a), .phase_b(ph_b),
    .index(idx));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic act_out(input logic [1:0] act, input logic old);
    case (act)
      ACT_SET: return 1'b1;
      ACT_CLEAR: return 1'b0;
      ACT_TOGGLE: return ~old;
      default: return old;
    endcase
  endfunction

  // waveform mode, event on ext clock 0 so line B stays an output
  function automatic tcwq_mode_t wave_mode(input logic [1:0] shape);
    tcwq_mode_t r;
    r = '0;
    r.wave = 1'b1;
    r.shape = shape;
    r.evt_src = EVT_X0;
    return r;
  endfunction

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  // strobe dropped at the following edge, so calls never collide
  task automatic wr(input tcwq_addr_t a, input tcwq_word_t d);
    @(posedge mclk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr_s <= 1'b0;
    #1;
  endtask

  task automatic rd(input tcwq_addr_t a, output tcwq_word_t d);
    @(posedge mclk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd_s <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic trig;
    wr(OFS_CTRL, 32'h1 << CTRL_SWTRG_BIT);
  endtask

  task automatic move;
    @(posedge mclk);
    step <= 1'b1;
    @(posedge mclk);
    step <= 1'b0;
    cyc(5);
  endtask

  initial
  begin
    #750000;
    num_errors++;
    wrap_up;
  end

  initial
  begin
    cyc(12);
    reset_n <= 1'b1;
    cyc(1);
    chk(32'({lao, laoe_n, lbo, lboe_n, dma}), 32'h0a);
    v0 = $random(seed);
    wr(OFS_CMP_A, v0);
    rd(OFS_CMP_A, v1);
    chk(v1, v0);
    rd(8'h3c, v1);
    chk(v1, 32'h0);
    $display("test reset and registers done");
    // line B as event source, event trigger enabled
    m = wave_mode(SHAPE_UP_FULL);
    m.evt_src = EVT_LINE_B;
    m.evt_edge = EDGE_RISE;
    m.evt_trig_en = 1'b1;
    m.act_e_a = ACT_SET;
    wr(OFS_MODE, m);
    wr(OFS_CTRL, 32'h1 << CTRL_CLKEN_BIT);
    cyc(2);
    chk(laoe_n, 1'b0);
    chk(lboe_n, 1'b1);
    rd(OFS_CV, v0);
    chk(v0, 32'h0);
    move;
    chk(lao, 1'b1);
    rd(OFS_CV, v0);
    rd(OFS_CV, v1);
    chk(v1 - v0, 32'h2);
    chk(dma_cnt, 0);
    $display("test line B event done");
    // capture mode trigger sources and edges, spaced reads
    m = '0;
    m.etrg_src = ETRG_LINE_A;
    wr(OFS_MODE, m);
    move;
    chk(dma_cnt, 0);
    for (int i = 0; i < 4; i++)
    begin
      e = '0;
      e.trig_a = (i == 1);
      wr(OFS_EXT, e);
      m.etrg_src = (i == 2) ? ETRG_LINE_B : (i == 1) ? ETRG_LINE_A : ETRG_PWM;
      m.etrg_edge = (i == 3) ? EDGE_BOTH : (i == 2) ? EDGE_FALL : EDGE_RISE;
      wr(OFS_MODE, m);
      n = dma_cnt;
      if (i == 2)
        move;
      else
      begin
        @(posedge mclk);
        pwm_a <= (i == 1);
        pwm_t <= (i != 1);
        cyc(2);
        pwm_a <= 1'b0;
        pwm_t <= 1'b0;
      end
      cyc(8);
      chk(dma_cnt, n + ((i == 3) ? 2 : 1));
      rd(OFS_CAPTURE, v0);
    end
    $display("test capture triggers done");
    // shape 00: compare C never triggers, sync restarts
    e = '0;
    wr(OFS_EXT, e);
    m = wave_mode(SHAPE_UP_FULL);
    m.c_trig = 1'b1;
    wr(OFS_CMP_C, 32'h3);
    wr(OFS_MODE, m);
    trig;
    cyc(20);
    rd(OFS_CV, v0);
    rd(OFS_CV, v1);
    chk(v1 - v0, 32'h2);
    chk(v0 > 32'h3, 1'b1);
    @(posedge mclk);
    sync_s <= 1'b1;
    @(posedge mclk);
    sync_s <= 1'b0;
    rd(OFS_CV, v2);
    chk(v2 < 32'h4, 1'b1);
    cyc(100);
    // turn to up/down while climbing, then flip with a trigger
    wr(OFS_CMP_C, 32'h3e8);
    wr(OFS_MODE, wave_mode(SHAPE_UPDN_C));
    rd(OFS_CV, v0);
    rd(OFS_CV, v1);
    c = v1 - v0;
    trig;
    rd(OFS_CV, v0);
    rd(OFS_CV, v1);
    chk(v1 - v0, -c);
    $display("test shape 00 and direction flip done");
    // period shapes stay within compare C and turn back
    for (int s = 2; s < 4; s++)
    begin
      // second period above the first, so the counter starts inside it
      c = 32'(8 * s - 8) + ($random(seed) & 32'h7);
      wr(OFS_CMP_C, c);
      wr(OFS_MODE, wave_mode(s[1:0]));
      trig;
      // clear a match flag left over from earlier tests
      rd(OFS_STATUS, v2);
      mx = '0;
      down = 1'b0;
      v0 = '0;
      for (int k = 0; k < 30; k++)
      begin
        rd(OFS_CV, v1);
        if (v1 > mx)
          mx = v1;
        if (v1 < v0)
          down = 1'b1;
        v0 = v1;
      end
      chk(mx <= c, 1'b1);
      chk(down, 1'b1);
      rd(OFS_STATUS, v2);
      chk(v2[ST_MC_BIT], 1'b1);
    end
    // compare C stops, then disables the counter clock
    for (int i = 0; i < 2; i++)
    begin
      m = wave_mode(SHAPE_UP_C);
      m.c_stop = (i == 0);
      m.c_dis = (i == 1);
      wr(OFS_CMP_C, 32'ha);
      wr(OFS_MODE, m);
      wr(OFS_CTRL, 32'h1 << CTRL_CLKEN_BIT);
      trig;
      cyc(30);
      rd(OFS_CV, v0);
      rd(OFS_CV, v1);
      chk(v1, v0);
      rd(OFS_STATUS, v2);
      chk(v2[3:2], (i == 0) ? 2'h1 : 2'h2);
    end
    $display("test period shapes and stop done");
    // output actions of trigger and compare A
    wr(OFS_CTRL, 32'h1 << CTRL_CLKEN_BIT);
    for (int a = 1; a < 4; a++)
    begin
      m = wave_mode(SHAPE_UP_FULL);
      m.act_s_a = a[1:0];
      m.act_s_b = a[1:0];
      wr(OFS_MODE, m);
      ea = act_out(a[1:0], lao);
      v0 = 32'(act_out(a[1:0], lbo));
      trig;
      cyc(3);
      chk(lao, ea);
      chk(lbo, v0[0]);
      chk(lboe_n, 1'b0);
    end
    m = wave_mode(SHAPE_UP_FULL);
    m.act_a_a = ACT_SET;
    m.act_s_a = ACT_CLEAR;
    wr(OFS_CMP_A, 32'hc);
    wr(OFS_MODE, m);
    trig;
    cyc(4);
    chk(lao, 1'b0);
    cyc(15);
    chk(lao, 1'b1);
    $display("test output actions done");
    // decoder off: index passes straight through
    for (int k = 0; k < 4; k++)
    begin
      move;
      chk(ch1, idx);
    end
    // divided clock: one tick per divider period
    e = '0;
    e.clk_sel = CLK_DIV;
    wr(OFS_EXT, e);
    rd(OFS_CV, v0);
    cyc(8 * DIV_DEFAULT - 2);
    rd(OFS_CV, v1);
    chk(v1 - v0, 32'h8);
    // decoder on: counter ticks once per phase edge
    e = '0;
    e.qd_en = 1'b1;
    e.clk_sel = CLK_X0;
    wr(OFS_EXT, e);
    wr(OFS_MODE, wave_mode(SHAPE_UP_FULL));
    trig;
    move;
    rd(OFS_CV, v0);
    n = 1 + ($random(seed) & 7);
    dir_dn <= 1'($random(seed));
    repeat (n) move;
    rd(OFS_CV, v1);
    chk(v1 - v0, 32'(n));
    $display("test decoder done");
    wrap_up;
  end
endmodule
